//--- rtl/charge_ctrl.sv
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
// Function
// (R1) Charge only with inhibit low, charge-off clear
// (R2) Pre-charge current, safety timer at quarter
// (R3) Reaching threshold moves to fast charge
// (R4) Stop when current reaches termination level
// (R5) Terminate only in CV, no loops active
// (R6) No termination in warm zone
// (R7) No termination during supplement mode
// (R8) Pause about 1 ms on current change
// (R9) Input droop loop disabled after reset
// (R10) Droop threshold 4.2-4.9 V, 100 mV steps
// (R11) Reduce input current at droop threshold
// (R12) Rail below battery+200mV reduces charge current
// (R13) Battery tracking disables rail droop loop
// (R14) Supplement entry and exit by offsets
// (R15) Droop loops set status and flags
// (R16) Doubling slows timer while droop active
// (R17) Overvoltage opens switch, pulses, sets bits
// (R18) Overvoltage gone clears status, resumes
// (R19) Overvoltage flag held until read after
// (R20) Input removed switches rail to battery
// (R21) Safety expiry disables charge, pulses, flags
// (R22) Fault held until inhibit or input toggles
// (R23) Comparator outputs synchronised before use
// (R24) Interrupt pulse width counted in cycles
module charge_ctrl
	import charger_pkg::*;
#(
	parameter int PAUSE_CYCLES = PAUSE_CYC,
	parameter int PULSE_CYCLES = INT_PULSE_CYC,
	parameter int TICK_CYCLES  = TICK_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire sense_t      sense_raw,
	output drive_t           drive,
	output logic             int_oe,
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready
);
	localparam int PW = $clog2(PAUSE_CYCLES + 1);
	localparam int TW = $clog2(TICK_CYCLES + 1);

	sense_t      sn;
	ctrl_t       ctrl;
	current_t    cur;
	state_t      state;
	state_t      next_state;
	logic [PW-1:0] pause_cnt;
	logic [TW-1:0] tick_cnt;
	logic [15:0] timer;
	logic        half;
	logic        supplement;
	logic        ovp_q;
	logic [3:0]  flags;
	logic        fault_int;

	// ==============================================================
	// Input synchronisation
	// (R23) Two flops per comparator
	sync2 #(.W($bits(sense_t))) u_sync (
		.clk  (clk),
		.rst  (rst),
		.din  (sense_raw),
		.dout (sn)
	);

	// ==============================================================
	// Bus decode
	wire        wr_take   = s_awready & s_awvalid & s_wvalid;
	wire        rd_take   = s_arready & s_arvalid;
	wire [31:0] wmask     = {{8{s_wstrb[3]}}, {8{s_wstrb[2]}},
	                         {8{s_wstrb[1]}}, {8{s_wstrb[0]}}};
	wire        wr_ctrl   = wr_take & (s_awaddr == ADDR_CTRL);
	wire        wr_cur    = wr_take & (s_awaddr == ADDR_CURRENT);
	wire        wr_ok     = wr_ctrl | wr_cur | (s_awaddr == ADDR_STATUS)
	                        | (s_awaddr == ADDR_FLAGS);
	wire        rd_ok     = (s_araddr == ADDR_CTRL) | (s_araddr == ADDR_CURRENT)
	                        | (s_araddr == ADDR_STATUS) | (s_araddr == ADDR_FLAGS);
	wire        rd_flags  = rd_take & (s_araddr == ADDR_FLAGS);
	wire [31:0] ctrl_new  = (ctrl & ~wmask) | (s_wdata & wmask);
	wire [31:0] cur_new   = (cur & ~wmask) | (s_wdata & wmask);
	wire        cur_chg   = wr_cur & (cur_new[23:0] != cur[23:0]);

	// ==============================================================
	// Loop and enable decisions
	// (R1) Enable needs valid input, inhibit low, bit clear
	wire en          = sn.in_valid & ~sn.overvoltage & ~sn.inhibit & ~ctrl.charge_off;
	// (R9) (R11) Input droop loop only when enabled
	wire in_droop    = ctrl.droop_enable & sn.input_droop;
	// (R12) (R13) Rail droop loop off in battery tracking
	wire rail_droop  = sn.rail_below_droop & ~ctrl.rail_tracking;
	// (R5) (R6) (R7) Termination qualification
	wire term_ok     = sn.cv_active & ~in_droop & ~rail_droop & ~sn.thermal_reg
	                   & ~sn.warm_zone & ~supplement
	                   & ~sn.rail_below_entry; // Entry blocks before the mode flop
	// (R4) Reached termination current
	wire term_hit    = (state == ST_FAST) & term_ok & sn.at_term;
	wire pause_end   = (pause_cnt == PW'(PAUSE_CYCLES - 1));
	wire tick        = (tick_cnt == TW'(TICK_CYCLES - 1));
	// (R16) Half speed while a droop loop is active
	wire slow        = ctrl.timer_doubling & (in_droop | rail_droop);
	wire advance     = tick & (~slow | half);
	wire [15:0] lim  = 16'(SAFETY_SEC) * (16'(ctrl.safety_sel) + 16'd1);
	// (R2) (R21) Pre-charge limit is a quarter of the full time
	wire expire      = ((state == ST_PRE) & (timer >= (lim >> 2)))
	                   | ((state == ST_FAST) & (timer >= lim));
	wire ovp_rise    = sn.overvoltage & ~ovp_q;

	// ==============================================================
	// Charge state machine
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (en)
					next_state = ST_PAUSE;
			end
			ST_PAUSE: begin
				// (R2) (R3) Phase chosen at end of pause
				if (!en)
					next_state = ST_IDLE;
				else if (pause_end)
					next_state = sn.below_precharge ? ST_PRE : ST_FAST;
			end
			ST_PRE: begin
				// (R8) (R3) Phase change pauses first
				if (!en)
					next_state = ST_IDLE;
				else if (expire)
					next_state = ST_FAULT;
				else if (!sn.below_precharge || cur_chg)
					next_state = ST_PAUSE;
			end
			ST_FAST: begin
				// (R4) (R8) Terminate or pause on new setting
				if (!en)
					next_state = ST_IDLE;
				else if (expire)
					next_state = ST_FAULT;
				else if (term_hit)
					next_state = ST_DONE;
				else if (cur_chg)
					next_state = ST_PAUSE;
			end
			ST_DONE: begin
				if (!en)
					next_state = ST_IDLE;
			end
			ST_FAULT: begin
				// (R22) Leave only on inhibit or input toggle
				if (sn.inhibit || !sn.in_valid)
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// State and pause counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state     <= ST_IDLE;
			pause_cnt <= '0;
		end else begin
			state     <= next_state;
			pause_cnt <= (state == ST_PAUSE && next_state == ST_PAUSE)
			             ? pause_cnt + 1'b1 : '0;
		end
	end

	// ==============================================================
	// Safety timer, ticking once per second
	// (R22) Timer cleared when leaving fault through idle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_cnt <= '0;
			half     <= 1'b0;
			timer    <= '0;
		end else begin
			tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
			if (tick)
				half <= ~half;
			if (state == ST_IDLE || state == ST_DONE)
				timer <= '0;
			else if (advance && state != ST_FAULT && timer != 16'hffff)
				timer <= timer + 16'd1;
		end
	end

	// ==============================================================
	// Supplement mode with entry/exit hysteresis
	// (R14) Enter below entry offset, leave above exit
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			supplement <= 1'b0;
		else if (sn.rail_below_entry)
			supplement <= 1'b1;
		else if (sn.rail_above_exit)
			supplement <= 1'b0;
	end

	// ==============================================================
	// Power stage controls, all registered
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			drive <= '0;
			ovp_q <= 1'b0;
		end else begin
			ovp_q <= sn.overvoltage;
			drive.charge_on <= (next_state == ST_PRE) | (next_state == ST_FAST);
			// (R17) (R18) Input switch follows overvoltage
			drive.input_switch_on <= ~sn.overvoltage;
			// (R11) Input current cut back by droop loop
			drive.input_current_reduce <= in_droop;
			// (R12) Charge current cut back by rail loop
			drive.charge_current_reduce <= rail_droop;
			drive.supplement_on <= supplement;
			// (R20) Rail to battery on input loss
			drive.rail_on_battery <= ~sn.in_valid & sn.batt_above_uvlo;
			// (R2) (R3) (R8) New current applied after pause
			if (state == ST_PAUSE && pause_end)
				drive.current_code <= sn.below_precharge ? cur.precharge_code
				                                         : cur.fast_code;
			drive.term_code <= cur.term_code;
			// (R10) Code n selects 4.2 V + n x 100 mV
			drive.input_droop_threshold <= ctrl.droop_sel;
		end
	end

	// ==============================================================
	// Interrupt pulse on overvoltage or safety expiry
	// (R17) (R21) One pulse per start; starts while a pulse runs are dropped
	assign fault_int = ovp_rise | ((state != ST_FAULT) & (next_state == ST_FAULT));

	pulse_gen #(.LEN(PULSE_CYCLES)) u_pulse (
		.clk   (clk),
		.rst   (rst),
		.start (fault_int),
		.pulse (int_oe)
	);

	// ==============================================================
	// Flags: set wins over clear-on-read
	// (R15) (R17) (R19) (R21) Flag set and clear terms
	wire [3:0] flag_set = {fault_int & ~ovp_rise, sn.overvoltage, rail_droop, in_droop};
	wire [3:0] flag_clr = rd_flags ? {1'b1, ~sn.overvoltage, 2'b11} : 4'h0;

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			flags <= 4'h0;
		else
			flags <= (flags & ~flag_clr) | flag_set;
	end

	// ==============================================================
	// Registers and AXI4-Lite slave
	// (R9) Control resets with droop loop disabled
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl <= CTRL_RST;
			cur  <= CURRENT_RST;
		end else begin
			if (wr_ctrl)
				ctrl <= {23'h0, ctrl_new[8:0]};
			if (wr_cur)
				cur <= {8'h0, cur_new[23:0]};
		end
	end

	// Write channel: address and data taken together
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_awready <= 1'b0;
			s_wready  <= 1'b0;
			s_bvalid  <= 1'b0;
			s_bresp   <= 2'b00;
		end else begin
			s_awready <= s_awvalid & s_wvalid & ~s_awready & ~s_bvalid;
			s_wready  <= s_awvalid & s_wvalid & ~s_awready & ~s_bvalid;
			if (wr_take) begin
				s_bvalid <= 1'b1;
				s_bresp  <= wr_ok ? 2'b00 : 2'b10;
			end else if (s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	// Read channel
	wire [31:0] status_word = {24'h0, drive.rail_on_battery, state == ST_FAULT,
	                           state == ST_DONE, drive.charge_on, sn.overvoltage,
	                           supplement, rail_droop, in_droop};
	wire [31:0] rd_word = (s_araddr == ADDR_CTRL)    ? ctrl :
	                      (s_araddr == ADDR_CURRENT) ? cur :
	                      (s_araddr == ADDR_STATUS)  ? status_word :
	                      (s_araddr == ADDR_FLAGS)   ? {28'h0, flags} : 32'h0;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h0;
			s_rresp   <= 2'b00;
		end else begin
			s_arready <= s_arvalid & ~s_arready & ~s_rvalid;
			if (rd_take) begin
				s_rvalid <= 1'b1;
				s_rdata  <= rd_word;
				s_rresp  <= rd_ok ? 2'b00 : 2'b10;
			end else if (s_rready) begin
				s_rvalid <= 1'b0;
			end
		end
	end

	// ==============================================================
	// Checks
	sequence ovp_held_read_s;
		flags[2] && sn.overvoltage && rd_flags;
	endsequence

	sequence enter_pause_s;
		state != ST_PAUSE ##1 state == ST_PAUSE;
	endsequence

	// (R1) Disable removes charge switch
	AST_CHG_EN: assert property (@(posedge clk) disable iff (rst) // (R1)
		!en |=> !drive.charge_on)
		else $error("charge switch on without enable");

	// (R8) Charge held off in the first two cycles of pause
	AST_PAUSE_OFF: assert property (@(posedge clk) disable iff (rst) // (R8)
		enter_pause_s |-> !drive.charge_on [*2])
		else $error("charging during current-change pause");

	// (R5) No termination without qualification
	AST_TERM_QUAL: assert property (@(posedge clk) disable iff (rst) // (R5)
		(state == ST_FAST && !term_ok && en) |=> state != ST_DONE)
		else $error("termination while not qualified");

	// (R9) Disabled droop loop never acts
	AST_DROOP_OFF: assert property (@(posedge clk) disable iff (rst) // (R9)
		!ctrl.droop_enable |=> !drive.input_current_reduce)
		else $error("input droop loop acted while disabled");

	// (R13) Tracking mode disables rail loop
	AST_RAIL_TRACK: assert property (@(posedge clk) disable iff (rst) // (R13)
		ctrl.rail_tracking |=> !drive.charge_current_reduce)
		else $error("rail droop loop active in tracking mode");

	// (R17) Overvoltage opens switch and starts pulse
	AST_OVP_SW: assert property (@(posedge clk) disable iff (rst) // (R17)
		ovp_rise |=> !drive.input_switch_on && int_oe && flags[2])
		else $error("overvoltage response missing");

	// (R19) Flag survives read while fault present
	AST_OVP_FLAG: assert property (@(posedge clk) disable iff (rst) // (R19)
		ovp_held_read_s |=> flags[2])
		else $error("overvoltage flag cleared during fault");

	// (R21) Expiry disables charge and raises flag
	AST_SAFETY: assert property (@(posedge clk) disable iff (rst) // (R21)
		(expire && en) |=> state == ST_FAULT && !drive.charge_on && flags[3])
		else $error("safety expiry not handled");

	// (R14) Supplement held until exit offset
	AST_SUPP: assert property (@(posedge clk) disable iff (rst) // (R14)
		(supplement && !sn.rail_above_exit) |=> supplement)
		else $error("supplement mode left early");

	// (R20) Rail follows battery on input loss
	AST_BATT_RAIL: assert property (@(posedge clk) disable iff (rst) // (R20)
		(!sn.in_valid && sn.batt_above_uvlo) |=> drive.rail_on_battery)
		else $error("rail not switched to battery");
endmodule : charge_ctrl

//--- rtl/charger_pkg.sv
package charger_pkg;
	// ==============================================================
	// Timing
	localparam int CLK_MHZ       = 100;
	localparam int PAUSE_US      = 1000;
	localparam int PAUSE_CYC     = PAUSE_US * CLK_MHZ;
	localparam int INT_PULSE_US  = 128;
	localparam int INT_PULSE_CYC = INT_PULSE_US * CLK_MHZ;
	localparam int TICK_MS       = 1000;
	localparam int TICK_CYC      = TICK_MS * 1000 * CLK_MHZ;
	localparam int SAFETY_MIN    = 180;
	localparam int SAFETY_SEC    = SAFETY_MIN * 60;

	// ==============================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_CURRENT = 8'h04;
	localparam logic [7:0] ADDR_STATUS  = 8'h08;
	localparam logic [7:0] ADDR_FLAGS   = 8'h0c;

	// ==============================================================
	// Reset values
	localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
	localparam logic [31:0] CURRENT_RST = 32'h0005_0a32;

	// ==============================================================
	// Field layouts
	typedef struct packed {
		logic [22:0] unused;
		logic [1:0]  safety_sel;
		logic        rail_tracking;
		logic        timer_doubling;
		logic [2:0]  droop_sel;
		logic        droop_enable;
		logic        charge_off;
	} ctrl_t;

	typedef struct packed {
		logic [7:0] unused;
		logic [7:0] term_code;
		logic [7:0] precharge_code;
		logic [7:0] fast_code;
	} current_t;

	// Comparator outputs seen from the analog side
	typedef struct packed {
		logic inhibit;
		logic in_valid;
		logic overvoltage;
		logic below_precharge;
		logic cv_active;
		logic at_term;
		logic input_droop;
		logic rail_below_droop;
		logic rail_below_entry;
		logic rail_above_exit;
		logic thermal_reg;
		logic warm_zone;
		logic batt_above_uvlo;
	} sense_t;

	// Controls toward the power stage
	typedef struct packed {
		logic       charge_on;
		logic       input_switch_on;
		logic       input_current_reduce;
		logic       charge_current_reduce;
		logic       supplement_on;
		logic       rail_on_battery;
		logic [7:0] current_code;
		logic [7:0] term_code;
		logic [2:0] input_droop_threshold;
	} drive_t;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'b000001,
		ST_PAUSE = 6'b000010,
		ST_PRE   = 6'b000100,
		ST_FAST  = 6'b001000,
		ST_DONE  = 6'b010000,
		ST_FAULT = 6'b100000
	} state_t;
endpackage : charger_pkg

//--- rtl/sync2.sv
`timescale 1ns/1ns
// Two-stage synchroniser for asynchronous levels
module sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta;

	// ==============================================================
	// First stage feeds only the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			dout <= '0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule : sync2

//--- rtl/pulse_gen.sv
`timescale 1ns/1ns
// Fixed-width pulse counted in clock cycles
module pulse_gen #(
	parameter int LEN = 12800
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic start,
	output logic      pulse
);
	localparam int CW = $clog2(LEN + 1);
	logic [CW-1:0] cnt;

	// ==============================================================
	// (R24) Width by counting
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt   <= '0;
			pulse <= 1'b0;
		end else if (!pulse && start) begin
			cnt   <= '0;
			pulse <= 1'b1;
		end else if (pulse) begin
			cnt   <= cnt + 1'b1;
			pulse <= (cnt != CW'(LEN - 1));
		end
	end

	// (R24) Pulse ends at full width
	AST_PULSE_LEN: assert property (@(posedge clk) disable iff (rst) // (R24)
		$fell(pulse) |-> $past(cnt) == CW'(LEN - 1))
		else $error("interrupt pulse width wrong");
endmodule : pulse_gen

//--- dv/batt_model.sv
`timescale 1ns/1ns
// ==========================================
// Analog side: a battery that charges up to a set limit
module batt_model
	import charger_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire drive_t     drive,
	input  wire sense_t     cond,
	input  wire logic [7:0] limit,
	output sense_t          sense_raw
);
	logic [7:0] level;

	// Level rises only while the charge switch is on
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			level <= 8'h00;
		else if (level > limit)
			level <= limit;
		else if (drive.charge_on && level < limit)
			level <= level + 8'h01;
	end

	// Battery comparators from level, the rest as the bench sets them
	always_comb begin
		sense_raw                 = cond;
		sense_raw.below_precharge = level < 8'h1e;
		sense_raw.cv_active       = level >= 8'h3c;
		sense_raw.at_term         = level >= 8'h50;
	end
endmodule : batt_model

//--- dv/testbench.sv
`timescale 1ns/1ns
module testbench
	import charger_pkg::*;
;
	localparam int PAUSE = 20;
	localparam int PULSE = 8;
	typedef struct packed {
		logic [31:0] d;
		logic [31:0] m;
		logic [1:0]  r;
	} rexp_t;
	logic        clk;
	logic        rst;
	sense_t      cond;
	sense_t      sense_raw;
	drive_t      drive;
	logic        int_oe;
	logic [7:0]  limit;
	logic [7:0]  s_awaddr;
	logic [7:0]  s_araddr;
	logic [31:0] s_wdata;
	logic [31:0] s_rdata;
	logic [3:0]  s_wstrb;
	logic [1:0]  s_bresp;
	logic [1:0]  s_rresp;
	logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic        s_arvalid, s_arready, s_rvalid, s_rready;
	logic [7:0]  code;
	int          fail_count;
	int          comparisons;
	int          cnt;
	int          blk_pos[5] = '{6, 5, 2, 1, 4};
	logic [1:0]  exp_b[$];
	rexp_t       exp_r[$];

	charge_ctrl #(.PAUSE_CYCLES(PAUSE), .PULSE_CYCLES(PULSE), .TICK_CYCLES(4)) i_charge_ctrl (
		.clk, .rst, .sense_raw, .drive, .int_oe, .s_awaddr, .s_awvalid, .s_awready,
		.s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
		.s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
	batt_model i_batt_model (.clk, .rst, .drive, .cond, .limit, .sense_raw);

	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==========================================
	// Compare, report and end
	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, e, g);
		end
	endtask : chk

	task automatic chk1(input string name, input logic e, input logic g);
		chk(name, {31'h0, e}, {31'h0, g});
	endtask : chk1

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	task automatic give_up(input string name);
		chk(name, 32'h1, 32'h0);
		wrap_up();
	endtask : give_up

	// ==========================================
	// Register bus master
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int i;
		exp_b.push_back(r);
		@(posedge clk);
		s_awaddr  <= a;
		s_wdata   <= d;
		s_awvalid <= 1'b1;
		s_wvalid  <= 1'b1;
		s_bready  <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
			if (s_bvalid) break;
		end
		s_bready <= 1'b0;
		if (i == 50) give_up("write response");
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [1:0] r);
		int i;
		exp_r.push_back('{d: d, m: m, r: r});
		@(posedge clk);
		s_araddr  <= a;
		s_arvalid <= 1'b1;
		s_rready  <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (s_arready) s_arvalid <= 1'b0;
			if (s_rvalid) break;
		end
		s_rready <= 1'b0;
		if (i == 50) give_up("read response");
	endtask : axi_read

	task automatic wait_on(input logic v, input int lim);
		int i;
		for (i = 0; i < lim; i++) begin
			@(posedge clk);
			if (drive.charge_on === v) break;
		end
		if (i == lim) give_up("charge_on wait");
	endtask : wait_on

	// Scoreboard: each bus answer against the oldest note
	always @(posedge clk) begin : mon
		rexp_t e;
		if (s_bvalid && s_bready && exp_b.size() > 0)
			chk("bresp", {30'h0, exp_b.pop_front()}, {30'h0, s_bresp});
		if (s_rvalid && s_rready && exp_r.size() > 0) begin
			e = exp_r.pop_front();
			chk("rresp", {30'h0, e.r}, {30'h0, s_rresp});
			chk("rdata", e.d & e.m, s_rdata & e.m);
		end
	end

	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(88));
		rst         = 1'b1;
		cond        = 13'h0801;
		limit       = 8'h14;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
		s_awaddr    = 8'h00;
		s_araddr    = 8'h00;
		s_wdata     = 32'h0;
		s_wstrb     = 4'hf;
		fail_count  = 0;
		comparisons = 0;
		repeat (5) @(posedge clk);
		rst  <= 1'b0;
		cond <= 13'h0841;
		axi_read(ADDR_CTRL, CTRL_RST, 32'h1ff, 2'b00);
		axi_read(ADDR_CURRENT, CURRENT_RST, 32'hffffff, 2'b00);
		axi_read(8'h10, 32'h0, 32'hffffffff, 2'b10);
		axi_write(8'h10, 32'h1, 2'b10);
		chk1("input reduce", 1'b0, drive.input_current_reduce);
		cond <= 13'h0801;
		for (int k = 0; k < 8; k++) begin
			axi_write(ADDR_CTRL, {27'h0, k[2:0], 2'b10}, 2'b00);
			repeat (2) @(posedge clk);
			chk("droop threshold", {29'h0, k[2:0]}, {29'h0, drive.input_droop_threshold});
		end
		$display("test registers done");
		for (int k = 3; k >= 0; k--) begin
			cond.inhibit <= k[1];
			axi_write(ADDR_CTRL, {27'h0, 3'h7, 1'b1, k[0]}, 2'b00);
			repeat (PAUSE + 10) @(posedge clk);
			chk1("charge_on", k == 0, drive.charge_on);
		end
		chk("precharge code", 32'h0a, {24'h0, drive.current_code});
		code = 8'($urandom_range(1, 255));
		if (code == 8'h0a) code = 8'h0b;
		axi_write(ADDR_CURRENT, {8'h00, 8'h05, code, 8'h32}, 2'b00);
		repeat (3) @(posedge clk);
		chk1("paused", 1'b0, drive.charge_on);
		wait_on(1'b1, PAUSE + 10);
		chk("new code", {24'h0, code}, {24'h0, drive.current_code});
		limit <= 8'h46;
		wait_on(1'b0, 40);
		wait_on(1'b1, PAUSE + 10);
		chk("fast code", 32'h32, {24'h0, drive.current_code});
		chk("term code", 32'h05, {24'h0, drive.term_code});
		$display("test enable and phases done");
		repeat (60) @(posedge clk);
		cond <= 13'h0821;
		axi_write(ADDR_CTRL, 32'h5e, 2'b00);
		repeat (10) @(posedge clk);
		chk1("tracking reduce", 1'b0, drive.charge_current_reduce);
		axi_write(ADDR_CTRL, 32'h1e, 2'b00);
		repeat (10) @(posedge clk);
		chk1("rail reduce", 1'b1, drive.charge_current_reduce);
		limit <= 8'h5a;
		for (int k = 0; k < 5; k++) begin
			cond <= 13'h0801 | (13'h1 << blk_pos[k]);
			repeat (40) @(posedge clk);
			chk1("held", 1'b1, drive.charge_on);
			chk1("input reduce", k == 0, drive.input_current_reduce);
			chk1("charge reduce", k == 1, drive.charge_current_reduce);
			chk1("supplement", k == 4, drive.supplement_on);
		end
		cond <= 13'h0801;
		repeat (20) @(posedge clk);
		chk1("supplement held", 1'b1, drive.supplement_on);
		chk1("held", 1'b1, drive.charge_on);
		cond <= 13'h0809;
		repeat (20) @(posedge clk);
		chk1("supplement", 1'b0, drive.supplement_on);
		chk1("terminated", 1'b0, drive.charge_on);
		axi_read(ADDR_STATUS, 32'h20, 32'h30, 2'b00);
		axi_read(ADDR_FLAGS, 32'h3, 32'h3, 2'b00);
		axi_read(ADDR_FLAGS, 32'h0, 32'h3, 2'b00);
		$display("test termination done");
		cond <= 13'h0c01;
		cnt = 0;
		repeat (40) begin
			@(posedge clk);
			if (int_oe) cnt++;
		end
		chk("pulse length", PULSE, cnt);
		chk1("input switch", 1'b0, drive.input_switch_on);
		axi_read(ADDR_STATUS, 32'h8, 32'h8, 2'b00);
		axi_read(ADDR_FLAGS, 32'h4, 32'h4, 2'b00);
		axi_read(ADDR_FLAGS, 32'h4, 32'h4, 2'b00);
		cond <= 13'h0801;
		repeat (10) @(posedge clk);
		chk1("input switch", 1'b1, drive.input_switch_on);
		axi_read(ADDR_STATUS, 32'h0, 32'h8, 2'b00);
		axi_read(ADDR_FLAGS, 32'h4, 32'h4, 2'b00);
		axi_read(ADDR_FLAGS, 32'h0, 32'h4, 2'b00);
		$display("test overvoltage done");
		limit <= 8'h14;
		cond  <= 13'h1801;
		repeat (10) @(posedge clk);
		cond <= 13'h0801;
		for (cnt = 0; cnt < 12000; cnt++) begin
			@(posedge clk);
			if (int_oe) break;
		end
		chk1("precharge expiry", 1'b1, cnt > 10700 && cnt < 10950);
		chk1("charge after expiry", 1'b0, drive.charge_on);
		axi_read(ADDR_FLAGS, 32'h8, 32'h8, 2'b00);
		axi_read(ADDR_FLAGS, 32'h0, 32'h8, 2'b00);
		axi_read(ADDR_STATUS, 32'h40, 32'h40, 2'b00);
		cond <= 13'h1801;
		repeat (10) @(posedge clk);
		cond <= 13'h0801;
		wait_on(1'b1, PAUSE + 20);
		axi_read(ADDR_STATUS, 32'h0, 32'h40, 2'b00);
		axi_write(ADDR_CTRL, 32'h3e, 2'b00);
		cond <= 13'h1841;
		repeat (10) @(posedge clk);
		cond <= 13'h0841;
		for (cnt = 0; cnt < 24000; cnt++) begin
			@(posedge clk);
			if (int_oe) break;
		end
		chk1("doubled expiry", 1'b1, cnt > 21500 && cnt < 21800);
		axi_read(ADDR_FLAGS, 32'h9, 32'h9, 2'b00);
		$display("test safety timer done");
		cond <= 13'h0001;
		repeat (10) @(posedge clk);
		chk1("rail on battery", 1'b1, drive.rail_on_battery);
		chk1("charge off", 1'b0, drive.charge_on);
		cond <= 13'h0000;
		repeat (10) @(posedge clk);
		chk1("rail on battery", 1'b0, drive.rail_on_battery);
		$display("test input removal done");
		wrap_up();
	end
endmodule : testbench
